// ---- core/interval_timer_params.svh ----
// Register offsets, field positions and reset values of the interval timer
`ifndef INTERVAL_TIMER_PARAMS_SVH
`define INTERVAL_TIMER_PARAMS_SVH

// ***************************************************************
// Register byte offsets
// ***************************************************************
`define ITS_CTRL_OFF      12'h000
`define ITS_STATUS_OFF    12'h004
`define ITS_PRESET_OFF    12'h008
`define ITS_COUNT_OFF     12'h00C
`define ITS_TOD_OFF       12'h010

// ***************************************************************
// Control bit positions
// ***************************************************************
`define CTRL_CLEAR_BIT    0
`define CTRL_LOAD_BIT     1

// ***************************************************************
// Reset values and widths
// ***************************************************************
`define CTRL_RESET        2'h1
`define STAGE_WIDTH       4
`define DEF_STAGES        2
`define TOD_WIDTH         16

`endif

// ---- core/interval_timer_pkg.sv ----
// Types shared by the interval timer files
package interval_timer_pkg;

  typedef enum logic [1:0]
  {
    AXI_RESP_OKAY   = 2'b00,
    AXI_RESP_SLVERR = 2'b10
  } axi_resp_e;

  typedef enum logic [1:0]
  {
    TMR_CLEAR = 2'b00,
    TMR_RUN   = 2'b01,
    TMR_DONE  = 2'b10
  } tmr_state_e;

endpackage

// ---- core/counter_stage_if.sv ----
// Borrow and zero signals that chain the counter stages together
`timescale 1ns/1ps
interface counter_stage_if #(parameter int STAGES = 2);
  logic [STAGES-1:0] borrow_in;
  logic [STAGES-1:0] zero;

  modport stage
  (
    input  borrow_in,
    output zero
  );
  modport chain
  (
    output borrow_in,
    input  zero
  );
endinterface

// ---- core/down_counter_stage.sv ----
// One four-bit down-counter stage with parallel preset and clear
`timescale 1ns/1ps
`include "interval_timer_params.svh"
module down_counter_stage
  import interval_timer_pkg::*;
#(
  parameter int W   = `STAGE_WIDTH,
  parameter int IDX = 0
)
(
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // Control
  input  wire logic          clear,
  input  wire logic          load,
  input  wire logic [W-1:0]  preset,
  // Chain
  counter_stage_if.stage     link,
  // State
  output logic [W-1:0]       count
);

  logic [W-1:0] count_ff;

  // ***************************************************************
  // Count down on borrow-in, preset on load, hold zero on clear
  // ***************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clear)
      count_ff <= '0;
    else if (load)
      count_ff <= preset;
    else if (link.borrow_in[IDX])
      count_ff <= count_ff - W'(1);
  end

  assign link.zero[IDX] = (count_ff == '0);
  assign count          = count_ff;

endmodule

// ---- core/interval_timer_sequencer.sv ----
// Cascadable down-counting interval timer with AXI4-Lite control
//
// How it works
// - The core is a chain of identical four-bit down-counter stages sized by a parameter.
// - The terminal count output is high during the interval and falls when it expires.
// - Several preset sources share the timer; their codes are ORed onto the data inputs.
// - The coded time of day is readable by software.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "interval_timer_params.svh"
module interval_timer_sequencer
  import interval_timer_pkg::*;
#(
  parameter int STAGES  = `DEF_STAGES,
  parameter int SOURCES = 2
)
(
  // Clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // AXI4-Lite write address
  input  wire logic [11:0]                  s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0]                  s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // Coded switch presets, one group per interval source
  input  wire logic [SOURCES*STAGES*4-1:0]  switch_presets,
  // Coded time of day from the external clock system
  input  wire logic [`TOD_WIDTH-1:0]        time_of_day,
  // Timer pin
  output logic                              terminal_count_output
);

  localparam int CW = STAGES * `STAGE_WIDTH;

  // ***************************************************************
  // Register state
  // ***************************************************************
  logic          counter_clear_line_ff;
  logic          parallel_load_enable_ff;
  logic          aw_held_ff;
  logic          w_held_ff;
  logic [11:0]   awaddr_ff;
  logic [31:0]   wdata_ff;
  logic [3:0]    wstrb_ff;
  logic          bvalid_ff;
  logic [1:0]    bresp_ff;
  logic          rvalid_ff;
  logic [31:0]   rdata_ff;
  logic [1:0]    rresp_ff;
  logic          tc_ff;
  logic [CW-1:0] preset_bus;
  logic [CW-1:0] count;
  logic          do_write;

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == `ITS_CTRL_OFF) || (a == `ITS_STATUS_OFF) || (a == `ITS_PRESET_OFF)
              || (a == `ITS_COUNT_OFF) || (a == `ITS_TOD_OFF);
  endfunction

  // ***************************************************************
  // Preset sources wire-ORed onto the counter data inputs
  // ***************************************************************
  always_comb
  begin
    preset_bus = '0;
    for (int s = 0; s < SOURCES; s++)
      preset_bus = preset_bus | switch_presets[s*CW +: CW];
  end

  // ***************************************************************
  // Counter chain
  // ***************************************************************
  counter_stage_if #(.STAGES(STAGES)) chain_if ();

  genvar g;
  generate
    for (g = 0; g < STAGES; g++)
    begin : g_stage
      if (g == 0)
      begin : g_first
        assign chain_if.borrow_in[0] = tc_ff;
      end
      else
      begin : g_next
        assign chain_if.borrow_in[g] = tc_ff && (&chain_if.zero[g-1:0]);
      end
      down_counter_stage #(.W(`STAGE_WIDTH), .IDX(g)) u_stage
      (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clear   (counter_clear_line_ff),
        .load    (parallel_load_enable_ff),
        .preset  (preset_bus[g*`STAGE_WIDTH +: `STAGE_WIDTH]),
        .link    (chain_if),
        .count   (count[g*`STAGE_WIDTH +: `STAGE_WIDTH])
      );
    end
  endgenerate

  // ***************************************************************
  // Terminal output: high from load until the count reaches zero
  // ***************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn || counter_clear_line_ff)
      tc_ff <= 1'b0;
    else if (parallel_load_enable_ff)
      tc_ff <= (preset_bus != '0);
    else if (tc_ff && (count == CW'(1)))
      tc_ff <= 1'b0;
  end

  assign terminal_count_output = tc_ff;

  // ***************************************************************
  // AXI4-Lite write path; address and data taken in either order
  // ***************************************************************
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign do_write      = aw_held_ff && w_held_ff && !bvalid_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= 12'h000;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_ff <= 1'b1;
      awaddr_ff  <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_ff <= 1'b0;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_ff <= 1'b1;
      wdata_ff  <= s_axi_wdata;
      wstrb_ff  <= s_axi_wstrb;
    end
    else if (do_write)
      w_held_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= AXI_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= addr_known(awaddr_ff) ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // ***************************************************************
  // Control register; load is a level that software drops itself
  // ***************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      counter_clear_line_ff   <= 1'(`CTRL_RESET >> `CTRL_CLEAR_BIT);
      parallel_load_enable_ff <= 1'b0;
    end
    else if (do_write && awaddr_ff == `ITS_CTRL_OFF && wstrb_ff[0])
    begin
      counter_clear_line_ff   <= wdata_ff[`CTRL_CLEAR_BIT];
      parallel_load_enable_ff <= wdata_ff[`CTRL_LOAD_BIT];
    end
  end

  // ***************************************************************
  // AXI4-Lite read path
  // ***************************************************************
  assign s_axi_arready = !rvalid_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= AXI_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= addr_known(s_axi_araddr) ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
      unique case (s_axi_araddr)
        `ITS_CTRL_OFF:   rdata_ff <= {30'h0, parallel_load_enable_ff, counter_clear_line_ff};
        `ITS_STATUS_OFF: rdata_ff <= {31'h0, tc_ff};
        `ITS_PRESET_OFF: rdata_ff <= 32'(preset_bus);
        `ITS_COUNT_OFF:  rdata_ff <= 32'(count);
        `ITS_TOD_OFF:    rdata_ff <= 32'(time_of_day);
        default:         rdata_ff <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

endmodule

// ---- tb/preset_source_model.sv ----
// Coded switch sources and time-of-day clock facing the timer
`timescale 1ns/1ps
module preset_source_model
#(
  parameter int SOURCES = 2,
  parameter int BITS    = 8
)
(
  // Source select, zero for none, and its code
  input  wire logic [1:0]           sel,
  input  wire logic [BITS-1:0]      code,
  input  wire logic [15:0]          tod_in,
  // Lines into the timer
  output logic [SOURCES*BITS-1:0]   presets,
  output logic [15:0]               tod
);
  // Idle switches sit behind their diodes, so the data lines pull low
  always_comb
  begin
    presets = '0;
    for (int i = 0; i < SOURCES; i++)
      if (sel == i + 1)
        presets[i*BITS +: BITS] = code;
  end
  assign tod = tod_in;
endmodule

// ---- tb/interval_timer_sequencer_assertions.sv ----
// Bus handshake and timer pin checks for the interval timer
`timescale 1ns/1ps
module interval_timer_sequencer_assertions
(
  // Clock and reset
  input wire logic         aclk,
  input wire logic         aresetn,
  // Bus handshakes
  input wire logic         s_axi_awvalid,
  input wire logic         s_axi_awready,
  input wire logic         s_axi_wvalid,
  input wire logic         s_axi_wready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_bready,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic [31:0]  s_axi_rdata,
  input wire logic         s_axi_rvalid,
  input wire logic         s_axi_rready,
  // Timer pin
  input wire logic         terminal_count_output
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_due;
    ##2 s_axi_bvalid;
  endsequence
  a_write_resp_lat: assert property (both_taken |-> resp_due)
    else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready wrong");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_tc_idle_low: assert property ($rose(aresetn) |-> !terminal_count_output)
    else $error("timer pin high out of reset");
endmodule
bind interval_timer_sequencer interval_timer_sequencer_assertions chk (.*);

// ---- tb/interval_timer_sequencer_tb_top.sv ----
// Register-level test of the interval timer
`timescale 1ns/1ps
`include "interval_timer_params.svh"
module interval_timer_sequencer_tb_top
  import interval_timer_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, terminal_count_output;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs, sel;
  logic [15:0] switch_presets, time_of_day, tod_in;
  logic [7:0]  code;
  int          miscompares, checks, n, ticks, runs;
  logic        start_flag, done_flag;
  localparam logic [15:0] tod_key = 16'hA5C3;
  // Free-running edge count for interval lengths
  always @(posedge aclk) ticks <= ticks + 1;
  interval_timer_sequencer dut (.*);
  preset_source_model ps (.sel(sel), .code(code), .tod_in(tod_in),
                          .presets(switch_presets), .tod(time_of_day));
  always #5 aclk = ~aclk;
  // *****
  // Reporting
  // *****
  task automatic finish_test;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp_data(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
    cmp_data({30'h0, g}, {30'h0, e});
  endtask
  task automatic hang;
    miscompares++;
    finish_test();
  endtask
  // *****
  // Bus cycles, ready sampled at the falling edge where it is settled
  // *****
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
      if (tb)
        break;
    end
    if (n == 40)
      hang();
  endtask
  task automatic rd_reg(input logic [11:0] a);
    logic ta, tr;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      rdv = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ta)
        s_axi_arvalid <= 1'b0;
      if (tr)
        break;
    end
    if (n == 40)
      hang();
  endtask
  // One interval started the way the control program does it
  task automatic run_interval(input logic [1:0] s, input logic [7:0] p);
    int   t0;
    logic gate;
    sel        <= s;
    code       <= p;
    start_flag = 1'b1;
    rd_reg(`ITS_PRESET_OFF);
    cmp_data(rdv, {24'h0, p});
    rd_reg(`ITS_STATUS_OFF);
    cmp_data(rdv, 32'h0);
    gate = start_flag && !rdv[0];
    if (gate)
    begin
      done_flag = 1'b0;
      wr(`ITS_CTRL_OFF, 32'h0);
      wr(`ITS_CTRL_OFF, 32'h2);
      wr(`ITS_CTRL_OFF, 32'h0);
      start_flag = 1'b0;
    end
    gate = !(gate ^ gate);
    @(negedge aclk);
    t0 = ticks;
    cmp_data({31'h0, terminal_count_output}, 32'h1);
    // A second request now must find the timer busy
    start_flag = 1'b1;
    @(posedge aclk);
    rd_reg(`ITS_STATUS_OFF);
    cmp_data(rdv, 32'h1);
    start_flag = 1'b0;
    do
      @(negedge aclk);
    while (terminal_count_output === 1'b1 && ticks - t0 < 400);
    if (ticks - t0 >= 400)
      hang();
    // Load drops one edge before the write returns, then one step per edge
    cmp_data(32'(ticks - t0), {24'h0, p} - 32'h1);
    @(posedge aclk);
    rd_reg(`ITS_STATUS_OFF);
    cmp_data(rdv, 32'h0);
    rd_reg(`ITS_COUNT_OFF);
    cmp_data(rdv, 32'h0);
    wr(`ITS_CTRL_OFF, 32'h1);
  endtask
  // *****
  // Main sequence
  // *****
  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hF;
    {sel, code} = 10'h0;
    tod_in = 16'hA5C3;
    start_flag = 1'b0;
    done_flag = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(`ITS_CTRL_OFF);
    cmp_data(rdv, 32'h1);
    rd_reg(`ITS_TOD_OFF);
    cmp_data(rdv, 32'h0000A5C3);
    rd_reg(12'h100);
    cmp_resp(rs, AXI_RESP_SLVERR);
    cmp_data(rdv, 32'h0);
    wr(12'h100, 32'h3);
    cmp_resp(rs, AXI_RESP_SLVERR);
    sel  <= 2'h1;
    code <= 8'h07;
    wr(`ITS_CTRL_OFF, 32'h3);
    @(negedge aclk);
    cmp_data({31'h0, terminal_count_output}, 32'h0);
    @(posedge aclk);
    rd_reg(`ITS_COUNT_OFF);
    cmp_data(rdv, 32'h0);
    wr(`ITS_CTRL_OFF, 32'h1);
    run_interval(2'h1, 8'h05);
    // Timed routine: key match with the done flag clear, one pass only
    repeat (3)
    begin
      rd_reg(`ITS_TOD_OFF);
      if (rdv[15:0] == tod_key && !done_flag)
      begin
        run_interval(2'h2, 8'h12);
        done_flag = 1'b1;
        runs++;
      end
    end
    cmp_data(32'(runs), 32'h1);
    // Another routine's start clears the flag, so the key matches again
    run_interval(2'h1, 8'h05);
    rd_reg(`ITS_TOD_OFF);
    if (rdv[15:0] == tod_key && !done_flag)
      runs++;
    cmp_data(32'(runs), 32'h2);
    // Reset in mid interval drops the pin and restores the clear bit
    wr(`ITS_CTRL_OFF, 32'h0);
    wr(`ITS_CTRL_OFF, 32'h2);
    @(negedge aclk);
    cmp_data({31'h0, terminal_count_output}, 32'h1);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(`ITS_CTRL_OFF);
    cmp_data(rdv, 32'h1);
    rd_reg(`ITS_STATUS_OFF);
    cmp_data(rdv, 32'h0);
    finish_test();
  end
endmodule
